// ===== isas_pkg.sv
package isas_pkg;

    // ==========================================================
    // Geometry
    localparam int NUM_SECT   = 18;
    localparam int SAR_BITS   = 13;
    localparam int DATA_BITS  = 12;
    localparam int FIFO_DEPTH = 16;
    localparam int WORD_BITS  = DATA_BITS + 1;

    // ==========================================================
    // Schedule steps, 0-based (cycle 1 of the schedule is step 0)
    localparam logic [4:0] STEP_REF0      = 5'h00;
    localparam logic [4:0] STEP_AZ        = 5'h01;
    localparam logic [4:0] STEP_CAL       = 5'h02;
    localparam logic [4:0] STEP_SAMPLE    = 5'h03;
    localparam logic [4:0] STEP_SAR_FIRST = 5'h04;
    localparam logic [4:0] STEP_SAR_LAST  = 5'h10;
    localparam logic [4:0] STEP_XFER      = 5'h11;
    localparam logic [4:0] SCHED_LEN      = 5'h12;
    localparam logic [4:0] PHASE_RST      = 5'h00;
    localparam int         LATENCY_CYC    = 14;

    // ==========================================================
    // Reset values and codes
    localparam logic [SAR_BITS-1:0]  SAR_RST   = 13'h0000;
    localparam logic [WORD_BITS-1:0] WORD_RST  = 13'h0000;
    localparam logic [DATA_BITS-1:0] FULL_CODE = 12'hFFF;
    localparam logic [SAR_BITS-1:0]  MASK_ONE  = 13'h0001;

    // ==========================================================
    // Helpers
    // Section sect runs one step behind section sect-1
    function automatic logic [4:0] step_of(input logic [4:0] phase, input int sect);
        logic [5:0] sum;
        sum = {1'b0, phase} + {1'b0, SCHED_LEN} - 6'(sect);
        if (sum >= {1'b0, SCHED_LEN})
            sum = sum - {1'b0, SCHED_LEN};
        return sum[4:0];
    endfunction

    function automatic logic is_sar_step(input logic [4:0] step);
        return (step >= STEP_SAR_FIRST) && (step <= STEP_SAR_LAST);
    endfunction

    // Trial bit: MSB on the first decision step, LSB on the last
    function automatic logic [SAR_BITS-1:0] trial_mask(input logic [4:0] step);
        logic [4:0] sh;
        sh = STEP_SAR_LAST - step;
        return MASK_ONE << sh;
    endfunction

    // Over-range forces all data bits high
    function automatic logic [WORD_BITS-1:0] format_word(input logic [SAR_BITS-1:0] res);
        if (res[SAR_BITS-1])
            return {1'b1, FULL_CODE};
        return {1'b0, res[DATA_BITS-1:0]};
    endfunction

endpackage

// ===== isas_stream_if.sv
`timescale 1ns/100ps
interface isas_stream_if #(
    parameter int WIDTH = 13
);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ===== isas_fifo.sv
`timescale 1ns/100ps
module isas_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 16
) (
    input  wire logic   clk_sys,
    input  wire logic   rstn,
    input  wire logic   ce,
    isas_stream_if.snk  wr,
    isas_stream_if.src  rd
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
    localparam logic [AW:0]   CNT_FULL = (AW + 1)'(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wptr_ff;
    logic [AW-1:0]    nxt_wptr;
    logic [AW-1:0]    rptr_ff;
    logic [AW-1:0]    nxt_rptr;
    logic [AW:0]      cnt_ff;
    logic [AW:0]      nxt_cnt;
    logic             do_wr;
    logic             do_rd;

    assign wr.ready = (cnt_ff != CNT_FULL);
    assign rd.valid = (cnt_ff != '0);
    assign rd.data  = mem_ff[rptr_ff];

    // ==========================================================
    // Pointers and count
    always_comb begin
        do_wr    = ce && wr.valid && wr.ready;
        do_rd    = ce && rd.valid && rd.ready;
        nxt_wptr = wptr_ff;
        nxt_rptr = rptr_ff;
        nxt_cnt  = cnt_ff;
        if (do_wr) begin
            nxt_wptr = (wptr_ff == PTR_LAST) ? '0 : wptr_ff + 1'b1;
        end
        if (do_rd) begin
            nxt_rptr = (rptr_ff == PTR_LAST) ? '0 : rptr_ff + 1'b1;
        end
        if (do_wr && !do_rd) begin
            nxt_cnt = cnt_ff + 1'b1;
        end else if (do_rd && !do_wr) begin
            nxt_cnt = cnt_ff - 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wptr_ff <= '0;
            rptr_ff <= '0;
            cnt_ff  <= '0;
        end else begin
            wptr_ff <= nxt_wptr;
            rptr_ff <= nxt_rptr;
            cnt_ff  <= nxt_cnt;
        end
    end

    // Storage needs no reset; count guards every read
    always_ff @(posedge clk_sys) begin
        if (do_wr) begin
            mem_ff[wptr_ff] <= wr.data;
        end
    end

endmodule

// ===== isas_sequencer.sv
`timescale 1ns/100ps
// Operation
// [R01] Eighteen parallel SAR sections, shared references
// [R02] Eighteen-phase schedule from the single clock
// [R03] 18:1 13-bit selector feeds output word
// [R04] Sections sample the input in rotation
// [R05] Each schedule lasts eighteen cycles, then repeats
// [R06] Ref-zero, auto-zero, calibrate, sample, 13 decisions
// [R07] Output word is unsigned straight binary
// [R08] New output word every clock cycle
// [R09] Over-voltage recovery within one clock
// [R10] Adjacent sections one cycle apart; cycle 18 transfers
// [R11] Output word fourteen cycles after its sample
// [R12] Registered output; high drive control floats pins
// [R13] Over-range sets flag and forces data ones
// [R14] Selector advances with sampling rotation order
module isas_sequencer (
    input  wire logic                                          clk_sys,
    input  wire logic                                          rstn,
    input  wire logic                                          ce,
    input  wire logic [isas_pkg::NUM_SECT-1:0]                 cmp_in,
    input  wire logic                                          out_drive_n,
    output logic      [isas_pkg::NUM_SECT-1:0]                 ref0_sel,
    output logic      [isas_pkg::NUM_SECT-1:0]                 az_cmp_en,
    output logic      [isas_pkg::NUM_SECT-1:0]                 cal_cmp_en,
    output logic      [isas_pkg::NUM_SECT-1:0]                 sample_en,
    output logic      [isas_pkg::NUM_SECT*isas_pkg::SAR_BITS-1:0] dac_code,
    output logic      [isas_pkg::DATA_BITS-1:0]                sample_word_bits,
    output logic                                               overrange_flag,
    output logic                                               data_oe_n,
    output logic                                               cap_valid,
    input  wire logic                                          cap_ready,
    output logic      [isas_pkg::WORD_BITS-1:0]                cap_data,
    output logic                                               cap_drop
);
    localparam int NS = isas_pkg::NUM_SECT;
    localparam int SB = isas_pkg::SAR_BITS;
    localparam int WB = isas_pkg::WORD_BITS;

    logic [4:0]    phase_ff;
    logic [4:0]    nxt_phase;
    logic [4:0]    sect_step [NS];
    logic [SB-1:0] sar_ff [NS];
    logic [SB-1:0] nxt_sar [NS];
    logic [NS-1:0] done_ff;
    logic [NS-1:0] nxt_done;
    logic [WB-1:0] word_ff;
    logic [WB-1:0] nxt_word;
    logic          push_ff;
    logic          nxt_push;
    logic          drop_ff;
    logic          nxt_drop;
    logic          drv_meta_ff;
    logic          drv_ff;
    logic          nxt_drv_meta;
    logic          nxt_drv;
    logic [SB-1:0] xfer_res;
    logic          xfer_done;

    isas_stream_if #(.WIDTH(WB)) fill_if ();
    isas_stream_if #(.WIDTH(WB)) drain_if ();

    // ==========================================================
    // Phase generator
    always_comb begin
        nxt_phase = phase_ff;
        if (ce) begin
            nxt_phase = (phase_ff == isas_pkg::STEP_XFER) ? isas_pkg::PHASE_RST : phase_ff + 5'h01; // [R02] [R05]
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            phase_ff <= isas_pkg::PHASE_RST;
        end else begin
            phase_ff <= nxt_phase;
        end
    end

    // ==========================================================
    // Step of every section, shared by strobes, SAR and selector
    // One decode keeps all three views of the schedule in step
    always_comb begin
        for (int s = 0; s < NS; s++) begin
            sect_step[s] = isas_pkg::step_of(phase_ff, s); // [R10] [R04]
        end
    end

    // ==========================================================
    // Section strobes and trial codes
    always_comb begin
        for (int s = 0; s < NS; s++) begin
            ref0_sel[s]   = (sect_step[s] == isas_pkg::STEP_REF0); // [R06]
            az_cmp_en[s]  = (sect_step[s] == isas_pkg::STEP_AZ); // [R06]
            cal_cmp_en[s] = (sect_step[s] == isas_pkg::STEP_CAL); // [R06]
            sample_en[s]  = (sect_step[s] == isas_pkg::STEP_SAMPLE); // [R06] [R04]
            dac_code[s*SB +: SB] = isas_pkg::is_sar_step(sect_step[s])
                                   ? (sar_ff[s] | isas_pkg::trial_mask(sect_step[s]))
                                   : sar_ff[s];
        end
    end

    // ==========================================================
    // SAR registers
    always_comb begin
        nxt_done = done_ff;
        for (int s = 0; s < NS; s++) begin
            nxt_sar[s] = sar_ff[s];
            if (ce) begin
                // Cleared at every sample so an overdriven result cannot linger
                if (sect_step[s] == isas_pkg::STEP_SAMPLE) begin
                    nxt_sar[s]  = isas_pkg::SAR_RST; // [R09] [R01]
                    nxt_done[s] = 1'b1;
                end else if (isas_pkg::is_sar_step(sect_step[s]) && cmp_in[s]) begin
                    nxt_sar[s] = sar_ff[s] | isas_pkg::trial_mask(sect_step[s]); // [R06]
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            for (int s = 0; s < NS; s++) begin
                sar_ff[s] <= isas_pkg::SAR_RST;
            end
            done_ff <= '0;
        end else begin
            for (int s = 0; s < NS; s++) begin
                sar_ff[s] <= nxt_sar[s];
            end
            done_ff <= nxt_done;
        end
    end

    // ==========================================================
    // Transfer selector
    // Exactly one section sits in its transfer step
    always_comb begin
        xfer_res  = isas_pkg::SAR_RST;
        xfer_done = 1'b0;
        for (int s = 0; s < NS; s++) begin
            if (sect_step[s] == isas_pkg::STEP_XFER) begin
                xfer_res  = sar_ff[s]; // [R03] [R14] [R10]
                xfer_done = done_ff[s];
            end
        end
    end

    // ==========================================================
    // Output word and capture push
    always_comb begin
        nxt_word = word_ff;
        nxt_push = push_ff;
        nxt_drop = drop_ff;
        if (ce) begin
            nxt_word = isas_pkg::format_word(xfer_res); // [R13] [R07] [R08] [R11]
            nxt_push = xfer_done;
            // Sections cannot stall, so a full buffer loses the word
            nxt_drop = push_ff && !fill_if.ready;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            word_ff <= isas_pkg::WORD_RST;
            push_ff <= 1'b0;
            drop_ff <= 1'b0;
        end else begin
            word_ff <= nxt_word; // [R12]
            push_ff <= nxt_push;
            drop_ff <= nxt_drop;
        end
    end

    // ==========================================================
    // Drive-control synchroniser
    // Pin is asynchronous; only the second flop is read by logic
    always_comb begin
        nxt_drv_meta = drv_meta_ff;
        nxt_drv      = drv_ff;
        if (ce) begin
            nxt_drv_meta = out_drive_n;
            nxt_drv      = drv_meta_ff;
        end
    end

    // Resets to floating so pins never glitch active at power-up
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            drv_meta_ff <= 1'b1;
            drv_ff      <= 1'b1;
        end else begin
            drv_meta_ff <= nxt_drv_meta;
            drv_ff      <= nxt_drv; // [R12]
        end
    end

    assign sample_word_bits = word_ff[isas_pkg::DATA_BITS-1:0];
    assign overrange_flag   = word_ff[WB-1]; // [R13]
    assign data_oe_n        = drv_ff; // [R12]
    assign cap_drop         = drop_ff;

    // ==========================================================
    // Capture buffer
    assign fill_if.valid  = push_ff;
    assign fill_if.data   = word_ff;
    assign cap_valid      = drain_if.valid;
    assign cap_data       = drain_if.data;
    assign drain_if.ready = cap_ready;

    isas_fifo #(
        .WIDTH (WB),
        .DEPTH (isas_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .ce      (ce),
        .wr      (fill_if),
        .rd      (drain_if)
    );

endmodule

// ===== isas_sequencer_asserts.sv
`timescale 1ns/100ps
module isas_sequencer_asserts (
    input wire logic                                             clk_sys,
    input wire logic                                             rstn,
    input wire logic                                             ce,
    input wire logic [isas_pkg::NUM_SECT-1:0]                    cmp_in,
    input wire logic                                             out_drive_n,
    input wire logic [isas_pkg::NUM_SECT-1:0]                    ref0_sel,
    input wire logic [isas_pkg::NUM_SECT-1:0]                    az_cmp_en,
    input wire logic [isas_pkg::NUM_SECT-1:0]                    sample_en,
    input wire logic [isas_pkg::NUM_SECT*isas_pkg::SAR_BITS-1:0] dac_code,
    input wire logic [isas_pkg::DATA_BITS-1:0]                   sample_word_bits,
    input wire logic                                             overrange_flag,
    input wire logic                                             data_oe_n,
    input wire logic                                             cap_valid,
    input wire logic                                             cap_ready,
    input wire logic [isas_pkg::WORD_BITS-1:0]                   cap_data
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    // ==========================================
    // Helpers: run of enabled edges, last strobe
    logic [4:0]  run_ff;
    logic [4:0]  nxt_run;
    logic [17:0] samp_ff;
    logic [17:0] nxt_samp;
    logic        msb_cmp;

    always_comb begin
        nxt_run  = ce ? ((run_ff == 5'h1F) ? run_ff : run_ff + 5'h01) : 5'h00;
        nxt_samp = ce ? sample_en : samp_ff;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            run_ff  <= 5'h00;
            samp_ff <= 18'h00000;
        end else begin
            run_ff  <= nxt_run;
            samp_ff <= nxt_samp;
        end
    end

    // Section now taking its first decision
    assign msb_cmp = |(cmp_in & samp_ff);

    // ==========================================
    // Properties
    one_sample_a: assert property ($onehot(sample_en)) else $error("sample strobe not one-hot");
    rotate_order_a: assert property (ce && |samp_ff |=> sample_en == {samp_ff[16:0], samp_ff[17]})
        else $error("sampling rotation broken");
    sched_az_a: assert property (ref0_sel[0] && ce |=> az_cmp_en[0] && !ref0_sel[0])
        else $error("auto-zero does not follow reference zero");
    first_trial_a: assert property (sample_en[0] && ce |=> dac_code[12:0] == 13'h1000)
        else $error("first trial code wrong");
    period_a: assert property ((sample_en[0] && ce) ##1 ce[*8] ##1 ce[*8] ##1 ce |=> sample_en[0])
        else $error("schedule period not eighteen");
    latency_a: assert property (run_ff >= 5'h10 |-> overrange_flag == $past(msb_cmp, 14))
        else $error("output latency wrong");
    force_ones_a: assert property (overrange_flag |-> sample_word_bits == 12'hFFF)
        else $error("over-range word not all ones");
    oe_sync_a: assert property (run_ff >= 5'h03 |-> data_oe_n == $past(out_drive_n, 2))
        else $error("drive enable delay wrong");
    hold_head_a: assert property (cap_valid && !cap_ready |=> cap_valid && $stable(cap_data))
        else $error("stream head changed while stalled");
endmodule

bind isas_sequencer isas_sequencer_asserts isas_sequencer_asserts_i (
    .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .cmp_in(cmp_in), .out_drive_n(out_drive_n),
    .ref0_sel(ref0_sel), .az_cmp_en(az_cmp_en), .sample_en(sample_en), .dac_code(dac_code),
    .sample_word_bits(sample_word_bits), .overrange_flag(overrange_flag), .data_oe_n(data_oe_n),
    .cap_valid(cap_valid), .cap_ready(cap_ready), .cap_data(cap_data)
);

// ===== isas_capture_model.sv
`timescale 1ns/100ps
module isas_capture_model (
    input  wire logic                           clk_sys,
    input  wire logic                           stall,
    input  wire logic                           cap_valid,
    input  wire logic [isas_pkg::WORD_BITS-1:0] cap_data,
    output logic                                cap_ready
);
    logic [isas_pkg::WORD_BITS-1:0] got [$];

    initial cap_ready = 1'b0;

    // Ready lags the stall request by one edge, like a registered sink
    always @(posedge clk_sys) begin
        if (cap_valid === 1'b1 && cap_ready)
            got.push_back(cap_data);
        cap_ready <= !stall;
    end
endmodule

// ===== isas_sequencer_tb.sv
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin bad_count++; $display("Error %0t: got %h want %h", $time, (a), (b)); end end
module isas_sequencer_tb;
    logic        clk_sys = 1'b0;
    logic        rstn = 1'b0;
    logic        ce = 1'b1;
    logic [17:0] cmp_in = 18'h00000;
    logic        out_drive_n = 1'b0;
    logic        stall = 1'b0;
    logic [17:0] ref0_sel, az_cmp_en, cal_cmp_en, sample_en;
    logic [233:0] dac_code;
    logic [11:0] sample_word_bits;
    logic        overrange_flag, data_oe_n, cap_valid, cap_ready, cap_drop;
    logic [12:0] cap_data;
    logic [12:0] tgt [18];
    logic [12:0] held_w;
    int          ph, st, cyc, drops, bad_count, check_count;
    // Analog level per row beside the word it must give
    logic [25:0] rows [6] = '{{13'h0000, 13'h0000}, {13'h0001, 13'h0001}, {13'h0A5A, 13'h0A5A},
                              {13'h0FFF, 13'h0FFF}, {13'h1000, 13'h1FFF}, {13'h1ABC, 13'h1FFF}};

    always #2 clk_sys = ~clk_sys;

    isas_sequencer isas_sequencer_i (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .cmp_in(cmp_in),
        .out_drive_n(out_drive_n), .ref0_sel(ref0_sel), .az_cmp_en(az_cmp_en), .cal_cmp_en(cal_cmp_en),
        .sample_en(sample_en), .dac_code(dac_code), .sample_word_bits(sample_word_bits),
        .overrange_flag(overrange_flag), .data_oe_n(data_oe_n), .cap_valid(cap_valid),
        .cap_ready(cap_ready), .cap_data(cap_data), .cap_drop(cap_drop));

    isas_capture_model isas_capture_model_i (.clk_sys(clk_sys), .stall(stall), .cap_valid(cap_valid),
        .cap_data(cap_data), .cap_ready(cap_ready));

    task automatic report_and_stop;
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ==========================================
    // Comparator stand-in: answers each trial from the section's level
    always @(posedge clk_sys) begin
        if (!rstn)
            ph = 0;
        else if (ce)
            ph = (ph + 1) % 18;
        if (cap_drop === 1'b1)
            drops++;
        if (!rstn || ce)
            for (int s = 0; s < 18; s++) begin
                st = (ph + 18 - s) % 18;
                cmp_in[s] <= (st >= 4 && st <= 16) ? tgt[s][16-st] : 1'b0;
            end
    end

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 2000) begin
            bad_count++;
            report_and_stop();
        end
    end

    // ==========================================
    // Main sequence
    initial begin
        foreach (tgt[s]) tgt[s] = 13'h0000;
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b1;
        for (int r = 0; r < 6; r++) begin
            #1;
            foreach (tgt[s]) tgt[s] = rows[r][25:13];
            repeat (40) @(posedge clk_sys);
            #1;
            `CHK({overrange_flag, sample_word_bits}, rows[r][12:0])
        end
        foreach (tgt[s]) tgt[s] = 13'(s) * 13'h00E3 + 13'h0011;
        repeat (40) @(posedge clk_sys);
        repeat (36) begin
            @(posedge clk_sys);
            #1;
            `CHK({overrange_flag, sample_word_bits}, tgt[ph])
        end
        `CHK(drops, 0)
        isas_capture_model_i.got.delete();
        // Sink stalls long enough to overflow the buffer
        @(posedge clk_sys);
        stall <= 1'b1;
        repeat (40) @(posedge clk_sys);
        stall <= 1'b0;
        repeat (40) @(posedge clk_sys);
        #1;
        `CHK(drops > 0, 1'b1)
        for (int i = 0; i < 15; i++)
            `CHK(isas_capture_model_i.got[i+1], (isas_capture_model_i.got[i] == 13'h0F24) ? 13'h0011 : isas_capture_model_i.got[i] + 13'h00E3)
        // Clock enable low freezes schedule and output word
        @(posedge clk_sys);
        ce <= 1'b0;
        @(posedge clk_sys);
        #1;
        held_w = {overrange_flag, sample_word_bits};
        repeat (5) @(posedge clk_sys);
        #1;
        `CHK(sample_en, 18'h00001 << ((ph + 15) % 18))
        `CHK({overrange_flag, sample_word_bits}, held_w)
        @(posedge clk_sys);
        ce <= 1'b1;
        @(posedge clk_sys);
        out_drive_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        `CHK(data_oe_n, 1'b1)
        @(posedge clk_sys);
        out_drive_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        `CHK(data_oe_n, 1'b0)
        @(posedge clk_sys);
        rstn <= 1'b0;
        @(posedge clk_sys);
        #1;
        `CHK({data_oe_n, cap_valid, cap_drop, overrange_flag, sample_word_bits}, 16'h8000)
        `CHK(sample_en, 18'h08000)
        // Release again: schedule restarts from phase zero
        @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        #1;
        `CHK(sample_en, 18'h10000)
        @(posedge clk_sys);
        #1;
        `CHK(sample_en, 18'h20000)
        report_and_stop();
    end
endmodule
